//--- hdl/sci_pkg.sv
package sci_pkg;
  // ----------------------------------------------------------------
  // counter bank geometry
  // ----------------------------------------------------------------
  localparam int NUM_CNT = 112;
  localparam int CNT_W = 24;
  localparam int NUM_LINK = 8;
  localparam int NUM_UTP = 12;
  localparam int CNT_PER = 4;
  localparam int UTP_BASE = 0;
  localparam int TX_BASE = 48;
  localparam int RX_BASE = 80;
  localparam int LINK_SRC = 5;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
  localparam logic [7:0] REG_RST = 8'h00;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MSTAT = 8'h00;
  localparam logic [7:0] ADDR_MEN = 8'h01;
  localparam logic [7:0] ADDR_LSTAT = 8'h08;
  localparam logic [7:0] ADDR_LEN = 8'h10;
  localparam logic [7:0] ADDR_SEL = 8'h20;
  localparam logic [7:0] ADDR_CMD = 8'h21;
  localparam logic [7:0] ADDR_BYTE0 = 8'h22;
  localparam logic [7:0] ADDR_BYTE1 = 8'h23;
  localparam logic [7:0] ADDR_BYTE2 = 8'h24;
  localparam logic [4:0] ADDR_GRP_MASK = 5'h1f;

  // ----------------------------------------------------------------
  // transfer command fields
  // ----------------------------------------------------------------
  localparam int CMD_ZERO_BIT = 4;
  localparam int CMD_IEN_BIT = 3;
  localparam int CMD_RDY_BIT = 7;
  localparam logic [2:0] OP_READ = 3'h5;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_IEN = 3'h2;

  // ----------------------------------------------------------------
  // link status fields
  // ----------------------------------------------------------------
  localparam int LST_OVF_BIT = 0;
  localparam int LST_LATCH_LSB = 1;
  localparam int LST_GRP_EVT_BIT = 6;
  localparam int LST_GRP_OVF_BIT = 7;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sci_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] op;
    logic ien;
    logic [7:0] sel;
  } sci_xfer_t;
endpackage

//--- hdl/sci_stats_irq.sv
// Functional notes
// RQ1: bank of 112 counters, 24 bits each, by utopia port, tx link, rx link.
// RQ2: hardware reset forces every counter to zero.
// RQ3: counter adds one per event, wraps all ones to zero and flags overflow.
// RQ4: four counters per utopia input: all, idle, unassigned, uncorrected hec cells.
// RQ5: four counters per tx link: total, idle/filler, stuff, control cells.
// RQ6: four per rx link: total or stuff, idle/filler, violation, bad hec.
// RQ7: rx link counters count only while that rx port is enabled.
// RQ8: software selects counter, writes read code; device copies count into snapshot bytes.
// RQ9: snapshot bytes hold captured count until the next read command.
// RQ10: software writes value bytes, selection, then write code; device preloads counter.
// RQ11: enable code sets selected counter overflow enable; mask code clears it.
// RQ12: counter raises overflow request only while its own enable is set.
// RQ13: summary status is live per-link OR of enabled link bits, unlatched.
// RQ14: interrupt pin low while any link is active and its summary enable set.
// RQ15: access to summary status register never changes interrupt pin level.
// RQ16: link status bits 5 to 1 latch the five receive link events.
// RQ17: link bit 0 is live OR of its 12 counter overflows and fifo overflow.
// RQ18: bit 0 clears on counter mask, overflow clear, or fifo enable off.
// RQ19: writing zero clears latches 1 to 5; zero to bit 0 does nothing.
// RQ20: writing one to bits 0 to 5 does nothing; reads clear nothing.
// RQ21: each link source passes upward only when its link enable bit is one.
// RQ22: two group event bits exist only in the link 0 status register.
// RQ23: command register carries a ready bit set when a transfer completes.
// RQ24: read or preload acts on the selection held when the command is written.
module sci_stats_irq (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire sci_pkg::sci_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic [47:0] utp_evt_i,
  input wire logic [31:0] tx_evt_i,
  input wire logic [31:0] rx_evt_i,
  input wire logic [7:0] rx_stuff_i,
  input wire logic [7:0] rx_stuff_sel_i,
  input wire logic [7:0] rx_port_en_i,
  input wire logic [39:0] link_evt_i,
  input wire logic [7:0] uni_fifo_ovf_i,
  input wire logic [7:0] fifo_ovf_en_i,
  input wire logic grp_ovf_i,
  input wire logic grp_evt_i,
  output logic irq_n_o
);
  localparam int N = sci_pkg::NUM_CNT;
  localparam int W = sci_pkg::CNT_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [W-1:0] cnt_reg [N]; // see RQ1
  logic [N-1:0] ien_reg;
  logic [N-1:0] ovf_reg;
  logic [N-1:0] ev;
  logic [N-1:0] wrap;
  logic [7:0] sel_reg;
  logic rdy_reg;
  sci_pkg::sci_xfer_t xfer_reg;
  logic [W-1:0] snap_reg;
  logic [7:0] men_reg;
  logic [7:0] len_reg [sci_pkg::NUM_LINK];
  logic [5:1] lat_reg [sci_pkg::NUM_LINK];
  logic grp_evt_reg;
  logic [7:0] lval [sci_pkg::NUM_LINK];
  logic [7:0] mstat;
  logic [7:0] lovf;
  logic [7:0] rdata_next;
  logic [W-1:0] cnt_sel;
  logic sel_ok;
  logic cmd_wr;
  logic cmd_ok;
  logic do_read;
  logic do_load;
  logic do_ien;
  logic lst_wr;
  logic [2:0] lst_idx;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // command codes carry a fixed zero in bit 4; anything else is ignored
  assign cmd_wr = req_i.wr && (req_i.addr == sci_pkg::ADDR_CMD);
  assign cmd_ok = (req_i.wdata[2:0] == sci_pkg::OP_READ ||
                   req_i.wdata[2:0] == sci_pkg::OP_WRITE ||
                   req_i.wdata[2:0] == sci_pkg::OP_IEN) &&
                  !req_i.wdata[sci_pkg::CMD_ZERO_BIT];
  assign lst_wr = req_i.wr && (req_i.addr[7:3] == sci_pkg::ADDR_LSTAT[7:3]);
  assign lst_idx = req_i.addr[2:0];
  // selections at or past the bank size are ignored rather than aliased
  assign sel_ok = xfer_reg.sel < 8'(N);
  assign do_read = xfer_reg.valid && sel_ok && xfer_reg.op == sci_pkg::OP_READ;
  assign do_load = xfer_reg.valid && sel_ok && xfer_reg.op == sci_pkg::OP_WRITE;
  assign do_ien = xfer_reg.valid && sel_ok && xfer_reg.op == sci_pkg::OP_IEN;
  assign cnt_sel = sel_ok ? cnt_reg[xfer_reg.sel[6:0]] : sci_pkg::CNT_RST;

  // ----------------------------------------------------------------
  // event routing to the counter bank
  // ----------------------------------------------------------------
  // utopia and tx counters run freely; rx counters wait for the port
  always_comb begin
    ev = '0;
    ev[sci_pkg::TX_BASE-1:sci_pkg::UTP_BASE] = utp_evt_i; // see RQ4
    ev[sci_pkg::RX_BASE-1:sci_pkg::TX_BASE] = tx_evt_i; // see RQ5
    for (int l = 0; l < sci_pkg::NUM_LINK; l++) begin
      for (int k = 0; k < sci_pkg::CNT_PER; k++) begin
        ev[sci_pkg::RX_BASE + l*4 + k] = rx_evt_i[l*4 + k] && rx_port_en_i[l]; // see RQ7
      end
      // stuff select swaps only counter 0 of the link; the other three keep counting
      if (rx_stuff_sel_i[l]) begin
        ev[sci_pkg::RX_BASE + l*4] = rx_stuff_i[l] && rx_port_en_i[l]; // see RQ6
      end
    end
  end

  // ----------------------------------------------------------------
  // counter bank
  // ----------------------------------------------------------------
  // preload wins over an event in the same cycle; that event is dropped
  for (genvar i = 0; i < N; i++) begin : g_cnt
    logic hit;
    assign hit = xfer_reg.sel == 8'(i);
    assign wrap[i] = ev[i] && cnt_reg[i] == sci_pkg::CNT_MAX && !(do_load && hit);

    // count value
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_reg[i] <= sci_pkg::CNT_RST; // see RQ2
      end else if (do_load && hit) begin
        cnt_reg[i] <= snap_reg; // see RQ10
      end else if (ev[i]) begin
        cnt_reg[i] <= cnt_reg[i] + 24'h000001; // see RQ3
      end
    end

    // per-counter overflow enable
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        ien_reg[i] <= 1'b0;
      end else if (do_ien && hit) begin
        ien_reg[i] <= xfer_reg.ien; // see RQ11
      end
    end

    // overflow request; a new wrap beats a mask, a preload beats the wrap
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        ovf_reg[i] <= 1'b0;
      end else if (wrap[i] && ien_reg[i]) begin
        ovf_reg[i] <= 1'b1; // see RQ12
      end else if (hit && (do_load || (do_ien && !xfer_reg.ien))) begin
        ovf_reg[i] <= 1'b0; // see RQ18
      end
    end

    cnt_wrap_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ3
      wrap[i] |=> cnt_reg[i] == sci_pkg::CNT_RST && (ovf_reg[i] == $past(ien_reg[i]) ||
      $past(ovf_reg[i])))
      else $error("counter did not wrap to zero with overflow");
    mask_clr_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ18
      do_ien && hit && !xfer_reg.ien && !wrap[i] |=> !ovf_reg[i] && !ien_reg[i])
      else $error("mask left overflow request standing");
    ovf_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ12
      !ovf_reg[i] && !ien_reg[i] |=> !ovf_reg[i])
      else $error("overflow request raised while disabled");
    // increment, preload and enable; a preload is kept out of the increment check
    cnt_inc_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ3
      ev[i] && !(do_load && hit) |=> cnt_reg[i] == $past(cnt_reg[i]) + 24'h000001)
      else $error("counter did not add one on an event");
    load_val_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ10
      do_load && hit |=> cnt_reg[i] == $past(snap_reg))
      else $error("preload did not take the snapshot value");
    ien_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ11
      do_ien && hit && xfer_reg.ien |=> ien_reg[i])
      else $error("enable code did not set the overflow enable");
  end

  // ----------------------------------------------------------------
  // counter selection and transfer command
  // ----------------------------------------------------------------
  // selection register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_reg <= sci_pkg::REG_RST;
    end else if (req_i.wr && req_i.addr == sci_pkg::ADDR_SEL) begin
      sel_reg <= req_i.wdata;
    end
  end

  // pending transfer: selection frozen at command time, done next cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_reg <= '0;
    end else if (cmd_wr && cmd_ok) begin
      xfer_reg.valid <= 1'b1;
      xfer_reg.op <= req_i.wdata[2:0];
      xfer_reg.ien <= req_i.wdata[sci_pkg::CMD_IEN_BIT];
      xfer_reg.sel <= sel_reg; // see RQ24
    end else begin
      xfer_reg.valid <= 1'b0;
    end
  end

  // ready drops on a command and rises once it has been carried out
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_reg <= 1'b1;
    end else if (cmd_wr && cmd_ok) begin
      rdy_reg <= 1'b0;
    end else if (xfer_reg.valid) begin
      rdy_reg <= 1'b1; // see RQ23
    end
  end

  // snapshot bytes; a read command beats a byte write in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      snap_reg <= sci_pkg::CNT_RST;
    end else if (do_read) begin
      snap_reg <= cnt_sel; // see RQ8 see RQ9
    end else if (req_i.wr && req_i.addr == sci_pkg::ADDR_BYTE0) begin
      snap_reg[7:0] <= req_i.wdata;
    end else if (req_i.wr && req_i.addr == sci_pkg::ADDR_BYTE1) begin
      snap_reg[15:8] <= req_i.wdata;
    end else if (req_i.wr && req_i.addr == sci_pkg::ADDR_BYTE2) begin
      snap_reg[23:16] <= req_i.wdata;
    end
  end

  // snapshot and ready; a second command right behind the first keeps ready low
  read_copy_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ8
    do_read |=> snap_reg == $past(cnt_sel) && (rdy_reg || $past(cmd_wr && cmd_ok)))
    else $error("snapshot does not hold selected count");
  snap_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ9
    !do_read && !(req_i.wr && (req_i.addr == sci_pkg::ADDR_BYTE0 ||
    req_i.addr == sci_pkg::ADDR_BYTE1 || req_i.addr == sci_pkg::ADDR_BYTE2)) |=>
    $stable(snap_reg))
    else $error("snapshot changed without a read command");
  ready_seq_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ23
    cmd_wr && cmd_ok |=> !rdy_reg ##1 rdy_reg || $past(cmd_wr && cmd_ok))
    else $error("ready bit sequence wrong");
  cmd_ignore_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ23
    cmd_wr && !cmd_ok && !xfer_reg.valid |=> $stable(rdy_reg))
    else $error("refused command code moved the ready bit");

  // ----------------------------------------------------------------
  // link status latches and enables
  // ----------------------------------------------------------------
  for (genvar l = 0; l < sci_pkg::NUM_LINK; l++) begin : g_link
    logic wr_me;
    assign wr_me = lst_wr && lst_idx == 3'(l);

    // latched events; an event in the clearing cycle is kept
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        lat_reg[l] <= '0;
      end else if (wr_me) begin
        lat_reg[l] <= (lat_reg[l] & req_i.wdata[5:1]) | link_evt_i[l*5 +: 5]; // see RQ19 see RQ20
      end else begin
        lat_reg[l] <= lat_reg[l] | link_evt_i[l*5 +: 5]; // see RQ16
      end
    end

    // link enable register
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        len_reg[l] <= sci_pkg::REG_RST;
      end else if (req_i.wr && req_i.addr == (sci_pkg::ADDR_LEN | 8'(l))) begin
        len_reg[l] <= req_i.wdata;
      end
    end

    // live overflow of this link's 12 counters plus its uni fifo
    assign lovf[l] = |ovf_reg[sci_pkg::UTP_BASE + l*4 +: 4] |
                     |ovf_reg[sci_pkg::TX_BASE + l*4 +: 4] |
                     |ovf_reg[sci_pkg::RX_BASE + l*4 +: 4] |
                     (uni_fifo_ovf_i[l] && fifo_ovf_en_i[l]); // see RQ17

    if (l == 0) begin : g_grp
      assign lval[l] = {grp_ovf_i, grp_evt_reg, lat_reg[l], lovf[l]}; // see RQ22
    end else begin : g_nogrp
      assign lval[l] = {2'b00, lat_reg[l], lovf[l]};
    end
    // recomputed every cycle, so a cleared source or enable can never leave it stale
    assign mstat[l] = |(lval[l] & len_reg[l]); // see RQ21 see RQ13

    latch_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ16
      link_evt_i[l*5] |=> lat_reg[l][1])
      else $error("link event not latched");
    latch_clr_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ19
      wr_me && !req_i.wdata[1] && !link_evt_i[l*5] |=> !lat_reg[l][1])
      else $error("zero write did not clear latch");
    one_write_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ20
      wr_me && req_i.wdata[1] && !lat_reg[l][1] && !link_evt_i[l*5] |=> !lat_reg[l][1])
      else $error("one write set a latch");
    // rx gate, stuff select and read side effects, checked per link
    rx_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ7
      !rx_port_en_i[l] && !do_load |=> $stable(cnt_reg[sci_pkg::RX_BASE + l*4]))
      else $error("rx counter moved while port disabled");
    stuff_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ6
      rx_stuff_sel_i[l] && rx_stuff_i[l] && rx_port_en_i[l] |-> ev[sci_pkg::RX_BASE + l*4])
      else $error("stuff event not routed to rx counter");
    read_nochg_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ20
      !wr_me && link_evt_i[l*5 +: 5] == 5'h00 |=> $stable(lat_reg[l]))
      else $error("link latch changed without write or event");
  end

  // group event latch, only in link 0; cleared by a zero write
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      grp_evt_reg <= 1'b0;
    end else if (grp_evt_i) begin
      grp_evt_reg <= 1'b1; // see RQ22
    end else if (lst_wr && lst_idx == 3'h0 && !req_i.wdata[sci_pkg::LST_GRP_EVT_BIT]) begin
      grp_evt_reg <= 1'b0;
    end
  end

  // group event must latch even when a clearing write lands in the same cycle
  grp_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ22
    grp_evt_i |=> grp_evt_reg)
    else $error("group event not latched");

  // ----------------------------------------------------------------
  // summary level and interrupt pin
  // ----------------------------------------------------------------
  // summary enable register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      men_reg <= sci_pkg::REG_RST;
    end else if (req_i.wr && req_i.addr == sci_pkg::ADDR_MEN) begin
      men_reg <= req_i.wdata;
    end
  end

  // pin is pure logic of state; status register access has no path here
  assign irq_n_o = ~|(mstat & men_reg); // see RQ14 see RQ15 see RQ13

  irq_pin_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ14
    lat_reg[0][1] && len_reg[0][1] && men_reg[0] |-> !irq_n_o)
    else $error("interrupt pin not asserted");
  irq_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ13
    men_reg == 8'h00 |-> irq_n_o)
    else $error("interrupt pin low with all links disabled");
  ovf_up_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RQ17
    ovf_reg[sci_pkg::TX_BASE] && len_reg[0][0] |-> mstat[0])
    else $error("counter overflow not reported on link");

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // unmapped addresses read zero; reads have no side effect
  always_comb begin
    rdata_next = 8'h00;
    if (req_i.addr[7:3] == sci_pkg::ADDR_LSTAT[7:3]) begin
      rdata_next = lval[lst_idx];
    end else if (req_i.addr[7:3] == sci_pkg::ADDR_LEN[7:3]) begin
      rdata_next = len_reg[req_i.addr[2:0]];
    end else begin
      unique case (req_i.addr)
        sci_pkg::ADDR_MSTAT: rdata_next = mstat;
        sci_pkg::ADDR_MEN: rdata_next = men_reg;
        sci_pkg::ADDR_SEL: rdata_next = sel_reg;
        sci_pkg::ADDR_CMD: rdata_next = {rdy_reg, 7'h00};
        sci_pkg::ADDR_BYTE0: rdata_next = snap_reg[7:0];
        sci_pkg::ADDR_BYTE1: rdata_next = snap_reg[15:8];
        sci_pkg::ADDR_BYTE2: rdata_next = snap_reg[23:16];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= sci_pkg::REG_RST;
    end else if (req_i.rd) begin
      rdata_o <= rdata_next;
    end
  end
endmodule

//--- verification/test_sci_stats_irq.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_sci_stats_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  sci_pkg::sci_req_t req_i = '0;
  logic [7:0] rdata_o;
  logic irq_n_o;
  logic [47:0] utp = '0;
  logic [31:0] tx = '0;
  logic [31:0] rx = '0;
  logic [7:0] stuff = '0;
  logic [7:0] stuff_sel = '0;
  logic [7:0] port_en = '0;
  logic [39:0] lev = '0;
  logic [7:0] fifo_ovf = '0;
  logic [7:0] fifo_en = '0;
  logic grp_ovf = 1'b0;
  logic grp_evt = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] e_v;
  logic [7:0] expq[$];
  int miscompares = 0;
  int n_checks = 0;
  int l, n, m;

  sci_stats_irq u_sci_stats_irq (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
    .rdata_o(rdata_o), .utp_evt_i(utp), .tx_evt_i(tx), .rx_evt_i(rx), .rx_stuff_i(stuff),
    .rx_stuff_sel_i(stuff_sel), .rx_port_en_i(port_en), .link_evt_i(lev),
    .uni_fifo_ovf_i(fifo_ovf), .fifo_ovf_en_i(fifo_en), .grp_ovf_i(grp_ovf),
    .grp_evt_i(grp_evt), .irq_n_o(irq_n_o));

  // ----------------------------------------------------------------
  // clock and read monitor
  // ----------------------------------------------------------------
  always #2.5 mclk_i = ~mclk_i;

  // remembers which edge took a read, so the answer is judged half a cycle later
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) rd_d <= 1'b0;
    else rd_d <= req_i.rd;
  end

  // oldest note against the registered read data, settled by the falling edge
  always @(negedge mclk_i) begin
    if (rd_d) begin
      if (expq.size() == 0) begin
        miscompares++;
        $display("BAD rdata expected none seen %h", rdata_o);
      end else begin
        e_v = expq.pop_front();
        `CHK("rdata", e_v, rdata_o)
      end
    end
  end

  // ----------------------------------------------------------------
  // bus and event tasks
  // ----------------------------------------------------------------
  // one request per falling edge; the next call replaces it, so no double drive
  task automatic acc(input logic w, input logic r, input int a, input int d);
    @(negedge mclk_i);
    req_i = '{wr: w, rd: r, addr: a[7:0], wdata: d[7:0]};
  endtask

  task automatic wr(input int a, input int d);
    acc(1'b1, 1'b0, a, d);
  endtask

  task automatic idle();
    acc(1'b0, 1'b0, 0, 0);
  endtask

  task automatic rd(input int a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, 1'b1, a, 0);
    idle();
  endtask

  // two idle edges let the transfer finish before anything reads it
  task automatic cmd(input int s, input int c);
    wr(sci_pkg::ADDR_SEL, s);
    wr(sci_pkg::ADDR_CMD, c);
    idle();
    idle();
  endtask

  task automatic cnt_rd(input int s, input logic [23:0] e);
    cmd(s, 8'h05);
    rd(sci_pkg::ADDR_CMD, 8'h80);
    rd(sci_pkg::ADDR_BYTE0, e[7:0]);
    rd(sci_pkg::ADDR_BYTE1, e[15:8]);
    rd(sci_pkg::ADDR_BYTE2, e[23:16]);
  endtask

  task automatic cnt_wr(input int s, input logic [23:0] v);
    wr(sci_pkg::ADDR_BYTE0, v[7:0]);
    wr(sci_pkg::ADDR_BYTE1, v[15:8]);
    wr(sci_pkg::ADDR_BYTE2, v[23:16]);
    cmd(s, 8'h01);
  endtask

  // single-cycle pulses with a gap, so each event is seen by exactly one edge
  task automatic ev(input int b, input int k, input int cnt);
    repeat (cnt) begin
      @(negedge mclk_i);
      case (b)
        0: utp[k] = 1'b1;
        1: tx[k] = 1'b1;
        2: rx[k] = 1'b1;
        3: lev[k] = 1'b1;
        4: stuff[k] = 1'b1;
        default: grp_evt = 1'b1;
      endcase
      @(negedge mclk_i);
      {utp, tx, rx, lev, stuff, grp_evt} = '0;
    end
  endtask

  task automatic wrap_up();
    if (expq.size() != 0) miscompares++;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog and tests
  // ----------------------------------------------------------------
  // about eighty times the expected run
  initial begin
    #200000;
    miscompares++;
    $display("BAD watchdog expected done seen hang");
    wrap_up();
  end

  initial begin
    void'($urandom(86));
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    rd(sci_pkg::ADDR_MSTAT, 8'h00);
    rd(sci_pkg::ADDR_MEN, 8'h00);
    rd(8'h30, 8'h00);
    for (l = 0; l < 8; l++) rd(sci_pkg::ADDR_LSTAT + l, 8'h00);
    `CHK("irq_n", 1'b1, irq_n_o)
    cnt_rd($urandom_range(0, 111), 24'h000000);
    $display("test reset done");
    l = $urandom_range(0, 11);
    for (m = 0; m < 4; m++) begin
      n = $urandom_range(1, 9);
      ev(0, l * 4 + m, n);
      cnt_rd(l * 4 + m, 24'(n));
    end
    l = $urandom_range(0, 7);
    for (m = 0; m < 4; m++) begin
      n = $urandom_range(1, 9);
      ev(1, l * 4 + m, n);
      cnt_rd(48 + l * 4 + m, 24'(n));
    end
    $display("test utopia and tx counters done");
    l = $urandom_range(0, 7);
    ev(2, l * 4, 3);
    cnt_rd(80 + l * 4, 24'h000000);
    port_en[l] = 1'b1;
    for (m = 0; m < 4; m++) begin
      n = $urandom_range(1, 9);
      ev(2, l * 4 + m, n);
      cnt_rd(80 + l * 4 + m, 24'(n));
    end
    stuff_sel[l] = 1'b1;
    cnt_wr(80 + l * 4, 24'h000010);
    ev(4, l, 2);
    cnt_rd(80 + l * 4, 24'h000012);
    ev(4, l, 1);
    rd(sci_pkg::ADDR_BYTE0, 8'h12);
    wr(sci_pkg::ADDR_SEL, 80 + l * 4);
    wr(sci_pkg::ADDR_CMD, 8'h05);
    wr(sci_pkg::ADDR_SEL, 0);
    idle();
    idle();
    rd(sci_pkg::ADDR_BYTE0, 8'h13);
    $display("test rx counters and snapshot done");
    cnt_wr(56, 24'hfffffe);
    cnt_rd(56, 24'hfffffe);
    cmd(60, 8'h15);
    rd(sci_pkg::ADDR_BYTE2, 8'hff);
    rd(sci_pkg::ADDR_CMD, 8'h80);
    cmd(56, 8'h0a);
    wr(sci_pkg::ADDR_LEN + 2, 8'h01);
    wr(sci_pkg::ADDR_MEN, 8'h04);
    ev(1, 8, 2);
    idle();
    rd(sci_pkg::ADDR_LSTAT + 2, 8'h01);
    rd(sci_pkg::ADDR_MSTAT, 8'h04);
    `CHK("irq_n", 1'b0, irq_n_o)
    wr(sci_pkg::ADDR_MSTAT, 8'h00);
    wr(sci_pkg::ADDR_LSTAT + 2, 8'h00);
    idle();
    `CHK("irq_n", 1'b0, irq_n_o)
    rd(sci_pkg::ADDR_LSTAT + 2, 8'h01);
    cnt_rd(56, 24'h000000);
    wr(sci_pkg::ADDR_LEN + 2, 8'h00);
    rd(sci_pkg::ADDR_MSTAT, 8'h00);
    `CHK("irq_n", 1'b1, irq_n_o)
    wr(sci_pkg::ADDR_LEN + 2, 8'h01);
    wr(sci_pkg::ADDR_MEN, 8'h00);
    rd(sci_pkg::ADDR_MSTAT, 8'h04);
    `CHK("irq_n", 1'b1, irq_n_o)
    cmd(56, 8'h02);
    rd(sci_pkg::ADDR_LSTAT + 2, 8'h00);
    cnt_wr(56, 24'hffffff);
    ev(1, 8, 1);
    idle();
    rd(sci_pkg::ADDR_LSTAT + 2, 8'h00);
    fifo_ovf[3] = 1'b1;
    wr(sci_pkg::ADDR_LEN + 3, 8'h01);
    rd(sci_pkg::ADDR_LSTAT + 3, 8'h00);
    fifo_en[3] = 1'b1;
    idle();
    rd(sci_pkg::ADDR_LSTAT + 3, 8'h01);
    fifo_en[3] = 1'b0;
    idle();
    rd(sci_pkg::ADDR_LSTAT + 3, 8'h00);
    $display("test overflow done");
    l = $urandom_range(1, 7);
    wr(sci_pkg::ADDR_MEN, 1 << l);
    ev(3, l * 5, 1);
    rd(sci_pkg::ADDR_MSTAT, 8'h00);
    wr(sci_pkg::ADDR_LEN + l, 8'h3e);
    m = 8'h02;
    for (n = 1; n < 5; n++) begin
      ev(3, l * 5 + n, 1);
      m = m | (2 << n);
      rd(sci_pkg::ADDR_LSTAT + l, m[7:0]);
    end
    rd(sci_pkg::ADDR_MSTAT, 8'(1 << l));
    `CHK("irq_n", 1'b0, irq_n_o)
    wr(sci_pkg::ADDR_LSTAT + l, 8'hff);
    rd(sci_pkg::ADDR_LSTAT + l, 8'h3e);
    wr(sci_pkg::ADDR_LSTAT + l, 8'hfd);
    rd(sci_pkg::ADDR_LSTAT + l, 8'h3c);
    wr(sci_pkg::ADDR_LSTAT + l, 8'h00);
    rd(sci_pkg::ADDR_LSTAT + l, 8'h00);
    rd(sci_pkg::ADDR_MSTAT, 8'h00);
    `CHK("irq_n", 1'b1, irq_n_o)
    ev(5, 0, 1);
    grp_ovf = 1'b1;
    idle();
    rd(sci_pkg::ADDR_LSTAT, 8'hc0);
    rd(sci_pkg::ADDR_LSTAT + l, 8'h00);
    wr(sci_pkg::ADDR_LSTAT, 8'h00);
    grp_ovf = 1'b0;
    idle();
    rd(sci_pkg::ADDR_LSTAT, 8'h00);
    $display("test link status done");
    idle();
    idle();
    wrap_up();
  end
endmodule
